// file: hdl/mdpc_top.sv
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module mdpc_top #(
  parameter int PITCH_W = mdpc_pkg::PITCH_W
) (
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  // axi4-lite slave
  input  wire logic [mdpc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [mdpc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // motion reference and motor side
  input  wire logic                       ref_req,
  input  wire logic                       ref_fwd,
  input  wire logic                       fwd_travel_inhibit,
  input  wire logic                       rev_travel_inhibit,
  input  wire logic                       linear_motor,
  input  wire logic                       sc_present,
  input  wire logic [PITCH_W-1:0]         auto_pitch,
  output logic                            motor_step,
  output logic                            motor_dir,
  output logic                            phase_order_select,
  output logic                            pitch_alarm,
  output logic                            pulse_out_a,
  output logic                            pulse_out_b,
  output logic                            irq
);

  // refuse a pitch width that the register fields cannot carry
  if (PITCH_W != mdpc_pkg::PITCH_W) begin : g_pitch_w_check
    $error("mdpc_top: PITCH_W must equal the package pitch width");
  end

  // register decode shared by read and write paths
  function automatic logic [2:0] reg_sel(input logic [mdpc_pkg::ADDR_W-1:0] addr);
    case (addr)
      mdpc_pkg::OFF_CTRL:       reg_sel = mdpc_pkg::SEL_CTRL;
      mdpc_pkg::OFF_PITCH:      reg_sel = mdpc_pkg::SEL_PITCH;
      mdpc_pkg::OFF_RESTART:    reg_sel = mdpc_pkg::SEL_RESTART;
      mdpc_pkg::OFF_STATUS:     reg_sel = mdpc_pkg::SEL_STATUS;
      mdpc_pkg::OFF_EFF_PITCH:  reg_sel = mdpc_pkg::SEL_EFF_PITCH;
      mdpc_pkg::OFF_IRQ_STATUS: reg_sel = mdpc_pkg::SEL_IRQ_STATUS;
      mdpc_pkg::OFF_IRQ_MASK:   reg_sel = mdpc_pkg::SEL_IRQ_MASK;
      default:                  reg_sel = mdpc_pkg::SEL_NONE;
    endcase
  endfunction

  logic                          aw_held_reg;
  logic [mdpc_pkg::ADDR_W-1:0]   aw_addr_reg;
  logic                          w_held_reg;
  logic [31:0]                   w_data_reg;
  logic [3:0]                    w_strb_reg;
  logic                          bvalid_reg;
  logic [1:0]                    bresp_reg;
  logic                          rvalid_reg;
  logic [31:0]                   rdata_reg;
  logic [1:0]                    rresp_reg;
  mdpc_pkg::mdpc_cfg_s           cfg_reg;
  mdpc_pkg::mdpc_cfg_s           act_reg;
  logic                          pitch_mod_reg;
  logic                          alarm_reg;
  logic                          boot_reg;
  logic                          restart_reg;
  logic [mdpc_pkg::IRQ_W-1:0]    irq_status_reg;
  logic [mdpc_pkg::IRQ_W-1:0]    irq_mask_reg;
  logic                          irq_reg;
  logic                          step_reg;
  logic                          dir_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // write path: address and data taken in either order, response after both
  wire         do_write   = aw_held_reg && w_held_reg && !bvalid_reg;
  wire [2:0]   wsel       = reg_sel(aw_addr_reg);
  wire         wr_ctrl    = do_write && (wsel == mdpc_pkg::SEL_CTRL) && w_strb_reg[0];
  wire         pitch_ok   = w_data_reg[PITCH_W-1:0] <= mdpc_pkg::PITCH_MAX
                            && w_data_reg[31:PITCH_W] == '0;
  wire         wr_pitch   = do_write && (wsel == mdpc_pkg::SEL_PITCH) && pitch_ok
                            && (&w_strb_reg[2:0]);
  wire         wr_restart = do_write && (wsel == mdpc_pkg::SEL_RESTART) && w_strb_reg[0]
                            && w_data_reg[mdpc_pkg::RESTART_BIT];
  wire         wr_istat   = do_write && (wsel == mdpc_pkg::SEL_IRQ_STATUS) && w_strb_reg[0];
  wire         wr_imask   = do_write && (wsel == mdpc_pkg::SEL_IRQ_MASK) && w_strb_reg[0];
  wire         wr_bad     = (wsel == mdpc_pkg::SEL_NONE) || (wsel == mdpc_pkg::SEL_STATUS)
                            || (wsel == mdpc_pkg::SEL_EFF_PITCH)
                            || ((wsel == mdpc_pkg::SEL_PITCH) && !pitch_ok);

  // channel handshakes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= mdpc_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_bad ? mdpc_pkg::RESP_SLVERR : mdpc_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path, one cycle after the address is taken
  wire [2:0]   rsel   = reg_sel(s_axi_araddr);
  wire         do_read = s_axi_arvalid && !rvalid_reg;
  wire [31:0]  st_word = {26'h0, pitch_mod_reg, linear_motor, sc_present, alarm_reg,
                          act_reg.phase, act_reg.dir};
  logic [31:0] rd_mux;

  always_comb begin
    case (rsel)
      mdpc_pkg::SEL_CTRL:       rd_mux = {30'h0, cfg_reg.phase, cfg_reg.dir};
      mdpc_pkg::SEL_PITCH:      rd_mux = {{(32-PITCH_W){1'b0}}, cfg_reg.pitch};
      mdpc_pkg::SEL_STATUS:     rd_mux = st_word;
      mdpc_pkg::SEL_EFF_PITCH:  rd_mux = {{(32-PITCH_W){1'b0}}, act_reg.pitch};
      mdpc_pkg::SEL_IRQ_STATUS: rd_mux = {30'h0, irq_status_reg};
      mdpc_pkg::SEL_IRQ_MASK:   rd_mux = {30'h0, irq_mask_reg};
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  // read data register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= mdpc_pkg::RESP_OKAY;
    end else if (do_read) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= (rsel == mdpc_pkg::SEL_NONE) ? mdpc_pkg::RESP_SLVERR : mdpc_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // staged settings, written by software, not yet in force
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg       <= mdpc_pkg::CFG_RST;
      pitch_mod_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        cfg_reg.dir   <= w_data_reg[mdpc_pkg::CTRL_DIR_BIT];
        cfg_reg.phase <= w_data_reg[mdpc_pkg::CTRL_PHASE_BIT];
      end
      if (wr_pitch) begin
        cfg_reg.pitch <= w_data_reg[PITCH_W-1:0];
        pitch_mod_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // restart: first edge after reset release, or a software restart write
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      boot_reg    <= 1'b1;
      restart_reg <= 1'b0;
    end else begin
      boot_reg    <= 1'b0;
      restart_reg <= boot_reg || wr_restart;
    end
  end

  // settings in force, taken only at restart
  wire         raise_alarm = linear_motor && sc_present && !pitch_mod_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      act_reg   <= mdpc_pkg::CFG_RST;
      alarm_reg <= 1'b0;
    end else if (restart_reg) begin
      act_reg.dir   <= cfg_reg.dir;
      act_reg.phase <= cfg_reg.phase;
      act_reg.pitch <= sc_present ? cfg_reg.pitch : auto_pitch;
      alarm_reg     <= raise_alarm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reference handling: inhibit follows reference, physical direction follows selection
  wire         blocked  = ref_fwd ? fwd_travel_inhibit : rev_travel_inhibit;
  wire         accepted = ref_req && !blocked;
  wire         ot_event = ref_req && blocked;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      step_reg <= 1'b0;
      dir_reg  <= 1'b0;
    end else begin
      step_reg <= accepted;
      if (accepted) begin
        dir_reg <= ref_fwd ^ act_reg.dir;
      end
    end
  end

  // emulated encoder pulses follow the reference, never the selection
  mdpc_quad_gen u_quad (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .step        (accepted),
    .fwd         (ref_fwd),
    .pulse_out_a (pulse_out_a),
    .pulse_out_b (pulse_out_b)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear, a new event wins over the clear
  wire [mdpc_pkg::IRQ_W-1:0] irq_events = {ot_event, restart_reg && raise_alarm};
  wire [mdpc_pkg::IRQ_W-1:0] irq_clr    = wr_istat ? w_data_reg[mdpc_pkg::IRQ_W-1:0] : '0;
  wire [mdpc_pkg::IRQ_W-1:0] irq_status_next = (irq_status_reg & ~irq_clr) | irq_events;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_status_reg <= '0;
      irq_mask_reg   <= '0;
      irq_reg        <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      if (wr_imask) begin
        irq_mask_reg <= w_data_reg[mdpc_pkg::IRQ_W-1:0];
      end
      irq_reg <= |(irq_status_next & (wr_imask ? w_data_reg[mdpc_pkg::IRQ_W-1:0]
                                               : irq_mask_reg));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output wiring, all from flops
  assign s_axi_awready      = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready       = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid       = bvalid_reg;
  assign s_axi_bresp        = bresp_reg;
  assign s_axi_arready      = !rvalid_reg;
  assign s_axi_rvalid       = rvalid_reg;
  assign s_axi_rdata        = rdata_reg;
  assign s_axi_rresp        = rresp_reg;
  assign motor_step         = step_reg;
  assign motor_dir          = dir_reg;
  assign phase_order_select = act_reg.phase;
  assign pitch_alarm        = alarm_reg;
  assign irq                = irq_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence seq_fwd_step;
    ref_req && ref_fwd && !fwd_travel_inhibit;
  endsequence

  sequence seq_rev_step;
    ref_req && !ref_fwd && !rev_travel_inhibit;
  endsequence

  AST_PHYS_DIR: assert property (@(posedge sys_clk) disable iff (!resetn)
    accepted |=> motor_step && (motor_dir == $past(ref_fwd ^ act_reg.dir)))
    else $error("motor direction does not follow reference and selection");

  AST_FWD_B_LEAD: assert property (@(posedge sys_clk) disable iff (!resetn)
    seq_fwd_step ##0 (pulse_out_a == pulse_out_b) |=> $changed(pulse_out_b) && $stable(pulse_out_a))
    else $error("forward step did not advance channel b first");

  AST_REV_A_LEAD: assert property (@(posedge sys_clk) disable iff (!resetn)
    seq_rev_step ##0 (pulse_out_a == pulse_out_b) |=> $changed(pulse_out_a) && $stable(pulse_out_b))
    else $error("reverse step did not advance channel a first");

  AST_PULSE_QUIET: assert property (@(posedge sys_clk) disable iff (!resetn)
    !accepted |=> $stable(pulse_out_a) && $stable(pulse_out_b))
    else $error("encoder pulses moved without a reference step");

  AST_OT_BLOCK: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ref_req && (ref_fwd ? fwd_travel_inhibit : rev_travel_inhibit))
      |=> !motor_step && irq_status_reg[mdpc_pkg::IRQ_OT_BIT])
    else $error("inhibited reference was not blocked");

  AST_LATCH_ONLY: assert property (@(posedge sys_clk) disable iff (!resetn)
    !restart_reg |=> $stable(act_reg))
    else $error("settings changed outside restart");

  AST_PHASE_TAKE: assert property (@(posedge sys_clk) disable iff (!resetn)
    restart_reg |=> phase_order_select == $past(cfg_reg.phase))
    else $error("phase order not taken at restart");

  AST_AUTO_PITCH: assert property (@(posedge sys_clk) disable iff (!resetn)
    (restart_reg && !sc_present) |=> act_reg.pitch == $past(auto_pitch))
    else $error("pitch not taken from encoder without converter");

  AST_ALARM_RAISE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (restart_reg && raise_alarm) |=> pitch_alarm ##1 irq_status_reg[mdpc_pkg::IRQ_ALARM_BIT])
    else $error("pitch alarm not raised at restart");

  AST_ALARM_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
    (pitch_alarm && !restart_reg) |=> pitch_alarm)
    else $error("pitch alarm cleared without restart");

endmodule // mdpc_top

// file: hdl/mdpc_pkg.sv
package mdpc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map, byte offsets on the axi4-lite slave
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_PITCH      = 8'h04;
  localparam logic [7:0]  OFF_RESTART    = 8'h08;
  localparam logic [7:0]  OFF_STATUS     = 8'h0c;
  localparam logic [7:0]  OFF_EFF_PITCH  = 8'h10;
  localparam logic [7:0]  OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h18;

  // register select codes returned by the address decoder
  localparam logic [2:0]  SEL_CTRL       = 3'h0;
  localparam logic [2:0]  SEL_PITCH      = 3'h1;
  localparam logic [2:0]  SEL_RESTART    = 3'h2;
  localparam logic [2:0]  SEL_STATUS     = 3'h3;
  localparam logic [2:0]  SEL_EFF_PITCH  = 3'h4;
  localparam logic [2:0]  SEL_IRQ_STATUS = 3'h5;
  localparam logic [2:0]  SEL_IRQ_MASK   = 3'h6;
  localparam logic [2:0]  SEL_NONE       = 3'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int          CTRL_DIR_BIT   = 0;
  localparam int          CTRL_PHASE_BIT = 1;
  localparam int          RESTART_BIT    = 0;
  localparam int          ST_DIR_BIT     = 0;
  localparam int          ST_PHASE_BIT   = 1;
  localparam int          ST_ALARM_BIT   = 2;
  localparam int          ST_SC_BIT      = 3;
  localparam int          ST_LINEAR_BIT  = 4;
  localparam int          ST_MOD_BIT     = 5;
  localparam int          IRQ_ALARM_BIT  = 0;
  localparam int          IRQ_OT_BIT     = 1;
  localparam int          IRQ_W          = 2;

  // pitch setting, units of 0.01 um
  localparam int          PITCH_W        = 23;
  localparam logic [22:0] PITCH_MAX      = 23'd6553600;
  localparam logic [22:0] PITCH_RST      = 23'h000000;
  localparam logic        DIR_RST        = 1'b0;
  localparam logic        PHASE_RST      = 1'b0;

  // axi response codes
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  // emulated encoder state, {a,b}
  typedef enum logic [1:0] {
    MDPC_Q00 = 2'b00,
    MDPC_Q01 = 2'b01,
    MDPC_Q11 = 2'b11,
    MDPC_Q10 = 2'b10
  } mdpc_quad_e;

  // configuration set, staged by software or in force since restart
  typedef struct packed {
    logic        dir;
    logic        phase;
    logic [22:0] pitch;
  } mdpc_cfg_s;

  localparam mdpc_cfg_s   CFG_RST        = '{dir: DIR_RST, phase: PHASE_RST, pitch: PITCH_RST};

endpackage

// file: hdl/mdpc_quad_gen.sv
`timescale 1ns/100ps
// quadrature pulse generator for the emulated encoder outputs
module mdpc_quad_gen (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic step,
  input  wire logic fwd,
  output logic      pulse_out_a,
  output logic      pulse_out_b
);

  mdpc_pkg::mdpc_quad_e state_reg;
  mdpc_pkg::mdpc_quad_e state_next;

  ////////////////////////////////////////////////////////////////////////////////
  // forward walks with b leading, reverse with a leading
  always_comb begin
    state_next = state_reg;
    if (step) begin
      case (state_reg)
        mdpc_pkg::MDPC_Q00: state_next = fwd ? mdpc_pkg::MDPC_Q01 : mdpc_pkg::MDPC_Q10;
        mdpc_pkg::MDPC_Q01: state_next = fwd ? mdpc_pkg::MDPC_Q11 : mdpc_pkg::MDPC_Q00;
        mdpc_pkg::MDPC_Q11: state_next = fwd ? mdpc_pkg::MDPC_Q10 : mdpc_pkg::MDPC_Q01;
        mdpc_pkg::MDPC_Q10: state_next = fwd ? mdpc_pkg::MDPC_Q00 : mdpc_pkg::MDPC_Q11;
        default:            state_next = mdpc_pkg::MDPC_Q00;
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= mdpc_pkg::MDPC_Q00;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs are the state flops themselves
  assign pulse_out_a = state_reg[1];
  assign pulse_out_b = state_reg[0];

endmodule // mdpc_quad_gen

// file: tb/mdpc_motor_model.sv
`timescale 1ns/100ps
// motor and encoder stand-in: counts position, reports motor kind
module mdpc_motor_model #(
  parameter logic [22:0] AUTO_PITCH = 23'h000fa0
) (
  input  wire logic   sys_clk,
  input  wire logic   resetn,
  input  wire logic   motor_step,
  input  wire logic   motor_dir,
  input  wire logic   lin_in,
  input  wire logic   sc_in,
  output logic        linear_motor,
  output logic        sc_present,
  output logic [22:0] auto_pitch,
  output int          pos
);
  // motor kind and self-read pitch, as fitted
  assign linear_motor = lin_in;
  assign sc_present   = sc_in;
  assign auto_pitch   = AUTO_PITCH;
  // encoder count follows each step, dir 1 counts up
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pos <= 0;
    end else if (motor_step) begin
      pos <= motor_dir ? pos + 1 : pos - 1;
    end
  end
endmodule // mdpc_motor_model

// file: tb/mdpc_top_tb_top.sv
`timescale 1ns/100ps
module mdpc_top_tb_top;
  logic        sys_clk = 1'b0, resetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        ref_req = 1'b0, ref_fwd = 1'b0, fwd_travel_inhibit = 1'b0;
  logic        rev_travel_inhibit = 1'b0, lin_in = 1'b1, sc_in = 1'b1, dir = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rs = 32'h8c1d, pv;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  q = 2'b00, s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [22:0] auto_pitch;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        linear_motor, sc_present, motor_step, motor_dir, phase_order_select;
  logic        pitch_alarm, pulse_out_a, pulse_out_b, irq;
  logic [33:0] sb[$];
  logic [2:0]  sq[$];
  int          errors = 0, n_checks = 0, pos, ep = 0;
  always #5 sys_clk = ~sys_clk;
  mdpc_top mdpc_top_i (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ref_req, .ref_fwd, .fwd_travel_inhibit, .rev_travel_inhibit,
    .linear_motor, .sc_present, .auto_pitch, .motor_step, .motor_dir, .phase_order_select,
    .pitch_alarm, .pulse_out_a, .pulse_out_b, .irq);
  mdpc_motor_model mdpc_motor_model_i (.sys_clk, .resetn, .motor_step, .motor_dir, .lin_in,
    .sc_in, .linear_motor, .sc_present, .auto_pitch, .pos);
  ////////////////////////////////////////////////////////////////////////////////
  // compare, verdict, random source, expected quadrature step
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [1:0] nq(input logic [1:0] s, input logic f);
    return f ? {s[0], ~s[1]} : {~s[0], s[1]}; // b leads forward, a leads reverse
  endfunction
  task automatic hang();
    errors++;
    conclude();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // bus master: note expected response, hold each channel until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    @(posedge sys_clk);
    sb.push_back({er, 32'h0});
    s_axi_awaddr <= a; s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    if (t == 50) hang();
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int t;
    @(posedge sys_clk);
    sb.push_back(e);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    if (t == 50) hang();
  endtask
  // reference step, noted only when not inhibited
  task automatic stp(input logic f);
    @(posedge sys_clk);
    ref_req <= 1'b1; ref_fwd <= f;
    if (!(f ? fwd_travel_inhibit : rev_travel_inhibit)) begin
      q = nq(q, f);
      sq.push_back({f ^ dir, q}); // forward with selection 0 is ccw, count-up
      ep += (f ^ dir) ? 1 : -1;
    end
  endtask
  task automatic rsteps(input int n);
    repeat (n) begin
      rs = xs(rs);
      stp(rs[0]);
    end
    @(posedge sys_clk);
    ref_req <= 1'b0;
    repeat (2) @(posedge sys_clk); // last steps reach the motor model
  endtask
  task automatic restart();
    wr(mdpc_pkg::OFF_RESTART, 32'h1, mdpc_pkg::RESP_OKAY);
    repeat (3) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // monitor: each result takes the oldest note
  always @(posedge sys_clk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready)
      chk({s_axi_bresp, 32'h0}, sb.size() ? sb.pop_front() : 34'h3ffffffff);
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, sb.size() ? sb.pop_front() : 34'h3ffffffff);
    if (motor_step === 1'b1)
      chk({motor_dir, pulse_out_a, pulse_out_b}, sq.size() ? sq.pop_front() : 3'bxxx);
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(pitch_alarm, 1'b1);
    rd(mdpc_pkg::OFF_STATUS, 34'h1c);
    $display("test 1 done");
    rsteps(16);
    chk(pos, ep);
    $display("test 2 done");
    wr(mdpc_pkg::OFF_CTRL, 32'h3, mdpc_pkg::RESP_OKAY);
    rsteps(2);
    chk(phase_order_select, 1'b0);
    restart();
    dir = 1'b1;
    chk(phase_order_select, 1'b1);
    rsteps(16);
    chk(pos, ep);
    $display("test 3 done");
    wr(mdpc_pkg::OFF_PITCH, 32'd6553601, mdpc_pkg::RESP_SLVERR);
    rs = xs(rs);
    pv = rs % 32'd6553601;
    wr(mdpc_pkg::OFF_PITCH, pv, mdpc_pkg::RESP_OKAY);
    chk(pitch_alarm, 1'b1);
    restart();
    chk(pitch_alarm, 1'b0);
    rd(mdpc_pkg::OFF_EFF_PITCH, {2'b00, pv});
    sc_in <= 1'b0;
    restart();
    rd(mdpc_pkg::OFF_EFF_PITCH, {11'h0, 23'h000fa0});
    $display("test 4 done");
    wr(mdpc_pkg::OFF_IRQ_STATUS, 32'h3, mdpc_pkg::RESP_OKAY);
    rd(mdpc_pkg::OFF_IRQ_STATUS, 34'h0);
    fwd_travel_inhibit <= 1'b1;
    stp(1'b1);
    stp(1'b0);
    @(posedge sys_clk);
    ref_req <= 1'b0;
    rd(mdpc_pkg::OFF_IRQ_STATUS, 34'h2);
    wr(mdpc_pkg::OFF_IRQ_MASK, 32'h2, mdpc_pkg::RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b1);
    wr(mdpc_pkg::OFF_IRQ_STATUS, 32'h2, mdpc_pkg::RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    rd(8'h40, {mdpc_pkg::RESP_SLVERR, 32'h0});
    $display("test 5 done");
    conclude();
  end
endmodule // mdpc_top_tb_top
